/* hdl/nv_sram_calendar_clock_pkg.sv */
package nv_sram_calendar_clock_pkg;
    // Array geometry
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned RAM_WORDS = 524288;
    localparam int unsigned DATA_W = 8;
    // Clock registers sit in the eight top locations
    localparam logic [18:0] CLK_BASE = 19'h7fff8;
    localparam logic [2:0] IDX_CENTURY = 3'h0;
    localparam logic [2:0] IDX_SECONDS = 3'h1;
    localparam logic [2:0] IDX_MINUTES = 3'h2;
    localparam logic [2:0] IDX_HOURS = 3'h3;
    localparam logic [2:0] IDX_DAY = 3'h4;
    localparam logic [2:0] IDX_DATE = 3'h5;
    localparam logic [2:0] IDX_MONTH = 3'h6;
    localparam logic [2:0] IDX_YEAR = 3'h7;
    // Control bit positions
    localparam int unsigned BIT_WRITE_HOLD = 7;
    localparam int unsigned BIT_READ_HOLD = 6;
    localparam int unsigned BIT_OSC_STOP = 7;
    localparam int unsigned BIT_BATT_OK = 7;
    localparam int unsigned BIT_FREQ_TEST = 6;
    // Value masks per register, unused bits read as zero
    localparam logic [7:0] MASK_CENTURY = 8'h3f;
    localparam logic [7:0] MASK_SECONDS = 8'h7f;
    localparam logic [7:0] MASK_MINUTES = 8'h7f;
    localparam logic [7:0] MASK_HOURS = 8'h3f;
    localparam logic [7:0] MASK_DAY = 8'h07;
    localparam logic [7:0] MASK_DATE = 8'h3f;
    localparam logic [7:0] MASK_MONTH = 8'h1f;
    localparam logic [7:0] MASK_YEAR = 8'hff;
    // Counter ranges in BCD
    localparam logic [7:0] MAX_CENTURY = 8'h39;
    localparam logic [7:0] MAX_SEC_MIN = 8'h59;
    localparam logic [7:0] MAX_HOURS = 8'h23;
    localparam logic [7:0] MAX_DAY = 8'h07;
    localparam logic [7:0] MAX_MONTH = 8'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;
    localparam logic [7:0] MIN_ZERO = 8'h00;
    localparam logic [7:0] MIN_ONE = 8'h01;
    localparam logic [7:0] MONTH_FEB = 8'h02;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_28 = 8'h28;
    // Reset values of the counters
    localparam logic [7:0] RST_TIME = 8'h00;
    localparam logic [7:0] RST_CAL = 8'h01;
    // Timing
    localparam longint unsigned CLK_HZ = 40000000;
    localparam longint unsigned TICK_PERIOD_S = 1;
    localparam longint unsigned FT_TOGGLE_HZ = 512;
    localparam longint unsigned SEC_CYCLES_DEF = CLK_HZ * TICK_PERIOD_S;
    localparam longint unsigned FT_CYCLES_DEF = CLK_HZ / FT_TOGGLE_HZ;
    localparam int unsigned DIV_W = 26;
    localparam int unsigned FT_W = 17;
endpackage : nv_sram_calendar_clock_pkg

/* hdl/bcd_step.sv */
`timescale 1ns/1ps
// One BCD counter stage: wraps from top to bottom and carries on wrap
module bcd_step (
    input wire logic [7:0] value,
    input wire logic [7:0] lo,
    input wire logic [7:0] hi,
    input wire logic en,
    output logic [7:0] nextVal,
    output logic carry
);
    // Wrap compare uses >= so a stray out-of-range value still recovers
    always_comb begin
        carry = en && (value >= hi);
        if (!en) begin
            nextVal = value;
        end else if (value >= hi) begin
            nextVal = lo;
        end else if (value[3:0] >= 4'h9) begin
            nextVal = {value[7:4] + 4'h1, 4'h0};
        end else begin
            nextVal = {value[7:4], value[3:0] + 4'h1};
        end
    end
endmodule : bcd_step

/* hdl/nv_sram_calendar_clock.sv */
`timescale 1ns/1ps
module nv_sram_calendar_clock
    import nv_sram_calendar_clock_pkg::*;
#(
    parameter longint unsigned SEC_CYCLES = SEC_CYCLES_DEF,
    parameter longint unsigned FT_CYCLES = FT_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dqIn,
    output logic [DATA_W-1:0] dqOut,
    output logic dqOe,
    input wire logic supplyOk,
    input wire logic batteryOk,
    output logic resetOutN
);
    // All module state except the byte array in one record
    typedef struct packed {
        logic [1:0] ceSync;          // Index 0 is the first stage
        logic [1:0] oeSync;
        logic [1:0] weSync;
        logic [1:0] supSync;
        logic [1:0] batSync;
        logic [ADDR_W-1:0] addrS1;
        logic [ADDR_W-1:0] addrS2;
        logic [DATA_W-1:0] dataS1;
        logic [DATA_W-1:0] dataS2;
        logic busy;                  // Write cycle in progress
        logic [ADDR_W-1:0] wrAddr;   // Last address seen while writing
        logic [DATA_W-1:0] wrData;
        logic [DIV_W-1:0] secDiv;    // One second divider
        logic [FT_W-1:0] ftDiv;      // Frequency test divider
        logic ftBit;
        logic [7:0][7:0] cnt;        // Internal counters
        logic [7:0][7:0] vis;        // Host-visible copy
        logic writeHold;
        logic readHold;
        logic oscStop;
        logic freqTest;
        logic [DATA_W-1:0] rdData;
        logic rdOe;
        logic rstOut;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [7:0] ram [RAM_WORDS];     // Byte array, no reset: contents persist
    logic [7:0][7:0] nxt;            // Counter chain outputs
    logic [7:0] carry;
    logic [7:0] mask [8];
    logic [7:0] daysInMonth;
    logic leapYear;
    logic tick;
    logic ftTick;
    logic selected;
    logic writing;
    logic commit;
    logic clkHit;
    logic rdClk;
    logic [2:0] idx;
    logic [7:0] clkRead;

    // Per-register masks of used bits
    assign mask[IDX_CENTURY] = MASK_CENTURY;
    assign mask[IDX_SECONDS] = MASK_SECONDS;
    assign mask[IDX_MINUTES] = MASK_MINUTES;
    assign mask[IDX_HOURS] = MASK_HOURS;
    assign mask[IDX_DAY] = MASK_DAY;
    assign mask[IDX_DATE] = MASK_DATE;
    assign mask[IDX_MONTH] = MASK_MONTH;
    assign mask[IDX_YEAR] = MASK_YEAR;

    // Dividers run on the device's own time base; stop bit clears and holds only the seconds divider at zero
    assign tick = !s_q.oscStop && (s_q.secDiv == DIV_W'(SEC_CYCLES - 1));
    assign ftTick = s_q.ftDiv == FT_W'(FT_CYCLES - 1);

    // Leap year every fourth year; century ignored, good until 2100
    assign leapYear = !s_q.cnt[IDX_YEAR][4] ? (s_q.cnt[IDX_YEAR][1:0] == 2'b00)
                                            : (s_q.cnt[IDX_YEAR][1:0] == 2'b10);

    // Month length from BCD month
    always_comb begin
        if (s_q.cnt[IDX_MONTH] == MONTH_FEB) begin
            daysInMonth = leapYear ? DAYS_29 : DAYS_28;
        end else if (s_q.cnt[IDX_MONTH] == 8'h04 || s_q.cnt[IDX_MONTH] == 8'h06 ||
                     s_q.cnt[IDX_MONTH] == 8'h09 || s_q.cnt[IDX_MONTH] == 8'h11) begin
            daysInMonth = DAYS_30;
        end else begin
            daysInMonth = DAYS_31;
        end
    end

    // BCD counter chain, seconds up to century
    bcd_step uSec (.value(s_q.cnt[IDX_SECONDS]), .lo(MIN_ZERO), .hi(MAX_SEC_MIN),
        .en(tick), .nextVal(nxt[IDX_SECONDS]), .carry(carry[IDX_SECONDS]));
    bcd_step uMin (.value(s_q.cnt[IDX_MINUTES]), .lo(MIN_ZERO), .hi(MAX_SEC_MIN),
        .en(carry[IDX_SECONDS]), .nextVal(nxt[IDX_MINUTES]), .carry(carry[IDX_MINUTES]));
    bcd_step uHour (.value(s_q.cnt[IDX_HOURS]), .lo(MIN_ZERO), .hi(MAX_HOURS),
        .en(carry[IDX_MINUTES]), .nextVal(nxt[IDX_HOURS]), .carry(carry[IDX_HOURS]));
    // Day of week steps at midnight, 1 to 7
    bcd_step uDay (.value(s_q.cnt[IDX_DAY]), .lo(MIN_ONE), .hi(MAX_DAY),
        .en(carry[IDX_HOURS]), .nextVal(nxt[IDX_DAY]), .carry(carry[IDX_DAY]));
    bcd_step uDate (.value(s_q.cnt[IDX_DATE]), .lo(MIN_ONE), .hi(daysInMonth),
        .en(carry[IDX_HOURS]), .nextVal(nxt[IDX_DATE]), .carry(carry[IDX_DATE]));
    bcd_step uMonth (.value(s_q.cnt[IDX_MONTH]), .lo(MIN_ONE), .hi(MAX_MONTH),
        .en(carry[IDX_DATE]), .nextVal(nxt[IDX_MONTH]), .carry(carry[IDX_MONTH]));
    bcd_step uYear (.value(s_q.cnt[IDX_YEAR]), .lo(MIN_ZERO), .hi(MAX_YEAR),
        .en(carry[IDX_MONTH]), .nextVal(nxt[IDX_YEAR]), .carry(carry[IDX_YEAR]));
    bcd_step uCent (.value(s_q.cnt[IDX_CENTURY]), .lo(MIN_ZERO), .hi(MAX_CENTURY),
        .en(carry[IDX_YEAR]), .nextVal(nxt[IDX_CENTURY]), .carry(carry[IDX_CENTURY]));

    // Bus decode on synchronised pins; bad supply deselects the part
    assign selected = !s_q.ceSync[1] && s_q.supSync[1];
    assign writing = selected && !s_q.weSync[1];
    // A write lands when the strobe goes away, RAM and clock alike
    assign commit = s_q.busy && !writing && s_q.supSync[1];
    assign clkHit = s_q.wrAddr >= CLK_BASE;
    assign rdClk = s_q.addrS2 >= CLK_BASE;
    assign idx = s_q.addrS2[2:0];

    // Clock register read view, taken from the buffered copy
    always_comb begin
        clkRead = s_q.vis[idx] & mask[idx];
        if (idx == IDX_CENTURY) begin
            clkRead[BIT_WRITE_HOLD] = s_q.writeHold;
            clkRead[BIT_READ_HOLD] = s_q.readHold;
        end else if (idx == IDX_SECONDS) begin
            clkRead[BIT_OSC_STOP] = s_q.oscStop;
            if (s_q.freqTest && !s_q.oscStop) begin
                clkRead[0] = s_q.ftBit;  // Test square wave on the LSB
            end
        end else if (idx == IDX_DAY) begin
            clkRead[BIT_BATT_OK] = s_q.batSync[1];
            clkRead[BIT_FREQ_TEST] = s_q.freqTest;
        end
    end

    // Next-state logic for everything but the byte array
    always_comb begin
        s_d = s_q;
        // Two-stage synchronisers for every pin
        s_d.ceSync = {s_q.ceSync[0], ceN};
        s_d.oeSync = {s_q.oeSync[0], oeN};
        s_d.weSync = {s_q.weSync[0], weN};
        s_d.supSync = {s_q.supSync[0], supplyOk};
        s_d.batSync = {s_q.batSync[0], batteryOk};
        s_d.addrS1 = addr;
        s_d.addrS2 = s_q.addrS1;
        s_d.dataS1 = dqIn;
        s_d.dataS2 = s_q.dataS1;
        s_d.rstOut = s_q.supSync[1];
        // Test divider keeps running whatever the bus does; seconds divider is held by the stop bit and restarted by a load
        s_d.secDiv = (tick || s_q.oscStop) ? '0 : s_q.secDiv + DIV_W'(1);
        s_d.ftDiv = ftTick ? '0 : s_q.ftDiv + FT_W'(1);
        if (ftTick) begin
            s_d.ftBit = !s_q.ftBit;
        end
        // Counters advance in one cycle, so nothing is ever half updated
        s_d.cnt = nxt;
        // Track the write strobe; address and data are those of its last cycle
        s_d.busy = writing;
        if (writing) begin
            s_d.wrAddr = s_q.addrS2;
            s_d.wrData = s_q.dataS2;
        end
        // Copy follows counters unless either hold bit is set
        if (!s_q.writeHold && !s_q.readHold) begin
            s_d.vis = s_q.cnt;
        end
        // Clock register writes; unused bits are dropped here
        if (commit && clkHit) begin
            s_d.vis[s_q.wrAddr[2:0]] = s_q.wrData & mask[s_q.wrAddr[2:0]];
            if (s_q.wrAddr[2:0] == IDX_CENTURY) begin
                s_d.writeHold = s_q.wrData[BIT_WRITE_HOLD];
                s_d.readHold = s_q.wrData[BIT_READ_HOLD];
            end else if (s_q.wrAddr[2:0] == IDX_SECONDS) begin
                s_d.oscStop = s_q.wrData[BIT_OSC_STOP];
            end else if (s_q.wrAddr[2:0] == IDX_DAY) begin
                s_d.freqTest = s_q.wrData[BIT_FREQ_TEST];
            end
            // Clearing write hold moves the loaded values into the counters
            if (s_q.writeHold && s_q.wrAddr[2:0] == IDX_CENTURY &&
                !s_q.wrData[BIT_WRITE_HOLD]) begin
                for (int i = 0; i < 8; i++) begin
                    s_d.cnt[i] = s_q.vis[i] & mask[i];
                end
                s_d.cnt[IDX_CENTURY] = s_q.wrData & MASK_CENTURY;
                s_d.secDiv = '0;  // Start a whole second from the load
            end
        end
        // Read drive only for a clean read cycle with good supply
        s_d.rdOe = selected && !s_q.oeSync[1] && s_q.weSync[1];
        s_d.rdData = rdClk ? clkRead : ram[s_q.addrS2];
        // Losing the supply mid-cycle throws the pending write away
        if (!s_q.supSync[1]) begin
            s_d.busy = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.ceSync <= 2'h3;
            s_q.oeSync <= 2'h3;
            s_q.weSync <= 2'h3;
            for (int i = 0; i < 8; i++) begin
                s_q.cnt[i] <= RST_TIME;
                s_q.vis[i] <= RST_TIME;
            end
            s_q.cnt[IDX_DAY] <= RST_CAL;
            s_q.cnt[IDX_DATE] <= RST_CAL;
            s_q.cnt[IDX_MONTH] <= RST_CAL;
        end else begin
            s_q <= s_d;
        end
    end

    // Byte array below the clock window; no reset so contents survive
    always_ff @(posedge clk) begin
        if (commit && !clkHit) begin
            ram[s_q.wrAddr] <= s_q.wrData;
        end
    end

    assign dqOut = s_q.rdData;
    assign dqOe = s_q.rdOe;
    assign resetOutN = s_q.rstOut;
endmodule : nv_sram_calendar_clock

/* bench/nv_sram_calendar_clock_monitor.sv */
`timescale 1ns/1ps
// Pin-level checker; sees only the top module's ports
module nv_sram_calendar_clock_monitor
    import nv_sram_calendar_clock_pkg::*;
#(
    parameter longint unsigned SEC_CYCLES = SEC_CYCLES_DEF,
    parameter longint unsigned FT_CYCLES = FT_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dqIn,
    input wire logic [DATA_W-1:0] dqOut,
    input wire logic dqOe,
    input wire logic supplyOk,
    input wire logic batteryOk,
    input wire logic resetOutN
);
    // Register addresses watched below
    localparam logic [18:0] DAY_A = CLK_BASE + 19'h4;
    localparam logic [18:0] HOUR_A = CLK_BASE + 19'h3;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Drive follows the pins three edges back (two sync flops and one register)
    drive_enable_a: assert property (dqOe == (!$past(ceN, 3) && !$past(oeN, 3)
        && $past(weN, 3) && $past(supplyOk, 3))) else $error("data drive mismatch");
    supply_quiet_a: assert property (!supplyOk [*3] |-> ##1 !dqOe)
        else $error("drive while supply bad");
    oe_release_a: assert property ($rose(oeN) |-> ##3 !dqOe)
        else $error("drive stayed after output enable release");
    write_no_drive_a: assert property (!weN [*4] |-> !dqOe)
        else $error("drive during write");
    reset_assert_a: assert property ($fell(supplyOk) |-> ##[1:4] !resetOutN)
        else $error("reset output not asserted");
    reset_hold_a: assert property (!supplyOk [*4] |-> !resetOutN)
        else $error("reset output released while supply bad");
    reset_release_a: assert property (supplyOk [*5] |-> resetOutN)
        else $error("reset output stuck low");
    hours_range_a: assert property (dqOe && $past(addr, 3) == HOUR_A
        && $past(addr, 4) == HOUR_A |-> dqOut <= MAX_HOURS) else $error("hours out of range");
    // Flag at the pins is the battery input as sampled three edges back
    batt_flag_a: assert property (dqOe && $past(addr, 3) == DAY_A && $past(addr, 4) == DAY_A
        |-> dqOut[7] == $past(batteryOk, 3)) else $error("battery flag wrong");
endmodule : nv_sram_calendar_clock_monitor

bind nv_sram_calendar_clock nv_sram_calendar_clock_monitor #(
    .SEC_CYCLES(SEC_CYCLES), .FT_CYCLES(FT_CYCLES)) mon (.clk(clk), .arst_n(arst_n),
    .ceN(ceN), .oeN(oeN), .weN(weN), .addr(addr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .supplyOk(supplyOk), .batteryOk(batteryOk), .resetOutN(resetOutN));

/* bench/bus_host.sv */
`timescale 1ns/1ps
// Host on the byte-wide pins; plain SRAM cycles for RAM and clock alike
module bus_host
    import nv_sram_calendar_clock_pkg::*;
(
    input wire logic clk,
    input wire logic [DATA_W-1:0] dqOut,
    output logic ceN,
    output logic oeN,
    output logic weN,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] dqIn,
    output logic [DATA_W-1:0] rdData,
    output logic rdStrobe
);
    initial begin
        {ceN, oeN, weN} = 3'h7;
        rdStrobe = 1'b0;
        addr = '0;
        dqIn = '0;
        rdData = '0;
    end
    // Byte write; addr and data settle two clocks early, since the pins are synced
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr <= a;
        dqIn <= d;
        repeat (2) @(posedge clk);
        ceN <= 1'b0;
        weN <= 1'b0;
        repeat (4) @(posedge clk);
        ceN <= 1'b1;
        weN <= 1'b1;
        repeat (2) @(posedge clk);
        // Two clocks after release the bus stops showing the old byte
        dqIn <= ~d;
        repeat (2) @(posedge clk);
    endtask : wr
    // Byte read; answer taken once the three-edge latency has passed
    task automatic rd(input logic [ADDR_W-1:0] a);
        addr <= a;
        ceN <= 1'b0;
        oeN <= 1'b0;
        repeat (5) @(posedge clk);
        rdData <= dqOut;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        ceN <= 1'b1;
        oeN <= 1'b1;
        addr <= ~a;
        repeat (3) @(posedge clk);
    endtask : rd
endmodule : bus_host

/* bench/nv_sram_calendar_clock_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module nv_sram_calendar_clock_tb_top;
    import nv_sram_calendar_clock_pkg::*;
    localparam longint unsigned SEC = 400; // Short second keeps the run brief
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic supplyOk = 1'b1;
    logic batteryOk = 1'b1;
    logic ceN, oeN, weN, dqOe, resetOutN, rdStrobe;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dqIn, dqOut, rdData;
    logic [7:0] expQ[$]; // Expected read bytes, oldest first
    logic [7:0] expV; // Note taken off the queue for one compare
    logic [18:0] ra[4];
    logic [7:0] rv[4];
    int n_fail = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    nv_sram_calendar_clock #(.SEC_CYCLES(SEC), .FT_CYCLES(8)) uut (.clk(clk), .arst_n(arst_n),
        .ceN(ceN), .oeN(oeN), .weN(weN), .addr(addr), .dqIn(dqIn), .dqOut(dqOut),
        .dqOe(dqOe), .supplyOk(supplyOk), .batteryOk(batteryOk), .resetOutN(resetOutN));
    bus_host host (.clk(clk), .dqOut(dqOut), .ceN(ceN), .oeN(oeN), .weN(weN), .addr(addr),
        .dqIn(dqIn), .rdData(rdData), .rdStrobe(rdStrobe));
    // Each returned byte is matched against the oldest note
    always @(posedge clk) begin
        if (rdStrobe === 1'b1) begin
            // Pop once only; an empty queue leaves an all-x note that mismatches any byte but an all-x one
            expV = (expQ.size() > 0) ? expQ.pop_front() : 8'hxx;
            `CHK("read data", expV, rdData)
        end
    end
    function automatic logic [18:0] reg_a(input int i);
        return CLK_BASE + 19'(i);
    endfunction : reg_a
    task automatic chk_rd(input logic [18:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.rd(a);
    endtask : chk_rd
    task automatic tally_and_finish;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // Watchdog, far above the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h131e6d0b));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        // Plain RAM, top RAM byte just below the clock block included
        for (int i = 0; i < 4; i++) begin
            ra[i] = (i == 0) ? CLK_BASE - 19'h1 : 19'($urandom % RAM_WORDS) & 19'h7fff7;
            rv[i] = 8'($urandom);
            host.wr(ra[i], rv[i]);
        end
        for (int i = 0; i < 4; i++) chk_rd(ra[i], rv[i]);
        // Set 23:59:59 Sat 28 Feb, year 04, century 20; unused bits written zero
        host.wr(reg_a(0), 8'h80);
        host.wr(reg_a(1), 8'h59);
        host.wr(reg_a(2), 8'h59);
        host.wr(reg_a(3), 8'h23);
        host.wr(reg_a(4), 8'h07);
        host.wr(reg_a(5), 8'h28);
        host.wr(reg_a(6), 8'h02);
        host.wr(reg_a(7), 8'h04);
        host.wr(reg_a(0), 8'h20);
        // Freeze the visible copy across a second boundary
        host.wr(reg_a(0), 8'h60);
        chk_rd(reg_a(1), 8'h59);
        chk_rd(reg_a(3), 8'h23);
        repeat (SEC) @(posedge clk);
        chk_rd(reg_a(1), 8'h59);
        host.wr(reg_a(0), 8'h20);
        chk_rd(reg_a(1), 8'h00);
        chk_rd(reg_a(2), 8'h00);
        chk_rd(reg_a(3), 8'h00);
        chk_rd(reg_a(4), 8'h81);
        chk_rd(reg_a(5), 8'h29);
        chk_rd(reg_a(6), 8'h02);
        chk_rd(reg_a(7), 8'h04);
        chk_rd(reg_a(0), 8'h20);
        // Supply drop: write is ignored, reset output goes low
        supplyOk <= 1'b0;
        repeat (6) @(posedge clk);
        host.wr(ra[1], ~rv[1]);
        `CHK("reset output", 1'b0, resetOutN)
        supplyOk <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("reset output", 1'b1, resetOutN)
        chk_rd(ra[1], rv[1]);
        // Load 10 s with the stop bit set; time must stand, test bit stays quiet
        host.wr(reg_a(0), 8'h80);
        host.wr(reg_a(1), 8'h90);
        host.wr(reg_a(0), 8'h20);
        host.wr(reg_a(4), 8'h41);
        repeat (SEC) @(posedge clk);
        chk_rd(reg_a(1), 8'h90);
        chk_rd(reg_a(4), 8'hc1);
        // Battery flag follows its input
        batteryOk <= 1'b0;
        repeat (4) @(posedge clk);
        chk_rd(reg_a(4), 8'h41);
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule : nv_sram_calendar_clock_tb_top
